/* File: verilog/rgc_pkg.sv */
// Purpose: Shared constants and types for the remap global command block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Command fields occupy bits 28 down to 24
package rgc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int RGC_AW = 8;
  localparam logic [RGC_AW-1:0] RGC_CMD_OFF = 8'h18;
  localparam logic [RGC_AW-1:0] RGC_STAT_OFF = 8'h1C;
  localparam logic [RGC_AW-1:0] RGC_IRTA_OFF = 8'h20;
  localparam logic [31:0] RGC_IRTA_RST = 32'h00000000;
  localparam logic [31:0] RGC_IRTP_RST = 32'h00000000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RGC_FL_BIT = 28;
  localparam int RGC_WBF_BIT = 27;
  localparam int RGC_QI_BIT = 26;
  localparam int RGC_IR_BIT = 25;
  localparam int RGC_TP_BIT = 24;
  localparam int RGC_FIELD_LSB = 24;
  localparam int RGC_CMD_LANE = 3;
  // Feature support mask, bit order fault log down to table pointer
  localparam logic [4:0] RGC_SUPPORT_RST = 5'h00;
  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RGC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RGC_RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic faultLog;
    logic flush;
    logic queuedInval;
    logic irqRemap;
    logic tablePtr;
  } rgc_stat_s;
  localparam rgc_stat_s RGC_STAT_RST = 5'h00;
  typedef enum logic [3:0] {
    RGC_IDLE = 4'b0001,
    RGC_LOAD = 4'b0010,
    RGC_FLUSH = 4'b0100,
    RGC_DRAIN = 4'b1000
  } rgc_state_e;
endpackage

/* File: verilog/rgc_sync2.sv */
// Purpose: Two-flop synchroniser for external levels
// Assumes: Inputs are slow levels held across several clocks
// Notes: First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module rgc_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta_q[i] <= din[i];
          dout[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: verilog/rgc_global_command.sv */
// Purpose: Upper global command fields with status and AXI4-Lite access
// Assumes: Flush and interrupt-drain helpers answer by level pins
// Notes: Support mask defaults to none, so all fields act reserved
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module rgc_global_command
  import rgc_pkg::*;
#(
  parameter logic [4:0] SUPPORT = rgc_pkg::RGC_SUPPORT_RST
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [rgc_pkg::RGC_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rgc_pkg::RGC_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic flushDonePin,
  input wire logic irqIdlePin,
  output logic flushReq,
  output logic faultLogMem,
  output logic queuedInvalOn,
  output logic irqRemapOn,
  output logic [31:0] irtPtr
);
  import rgc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pinSync;
  wire flushDoneS = pinSync[0];
  wire irqIdleS = pinSync[1];

  rgc_sync2 #(.WIDTH(2)) uSync (
    .mclk(mclk),
    .rst(rst),
    .din({irqIdlePin, flushDonePin}),
    .dout(pinSync)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  rgc_state_e state_q, state_d;
  rgc_stat_s stat_q;
  logic pendLoad_q, pendFlush_q, pendIr_q, irTarget_q;
  logic [31:0] irtAddr_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire supFl = SUPPORT[4];
  wire supWbf = SUPPORT[3];
  wire supQi = SUPPORT[2];
  wire supIr = SUPPORT[1];
  wire supTp = SUPPORT[0];

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire idle = (state_q == RGC_IDLE) && !pendLoad_q && !pendFlush_q && !pendIr_q;
  wire wrTake = awready_q && awvalid && wvalid;
  wire hitCmd = (awaddr == RGC_CMD_OFF);
  wire hitStat = (awaddr == RGC_STAT_OFF);
  wire hitIrta = (awaddr == RGC_IRTA_OFF);
  wire wrMapped = hitCmd || hitStat || hitIrta;
  wire cmdWr = wrTake && hitCmd && wstrb[RGC_CMD_LANE];
  wire irtaWr = wrTake && hitIrta;
  wire wrFl = cmdWr && supFl;
  wire wrWbf = cmdWr && supWbf && wdata[RGC_WBF_BIT];
  wire wrQi = cmdWr && supQi;
  wire wrIr = cmdWr && supIr && (wdata[RGC_IR_BIT] != irqRemapOn);
  wire wrTp = cmdWr && supTp && wdata[RGC_TP_BIT];

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  wire rdTake = arready_q && arvalid;
  wire rdStat = (araddr == RGC_STAT_OFF);
  wire rdIrta = (araddr == RGC_IRTA_OFF);
  wire rdCmd = (araddr == RGC_CMD_OFF);
  wire rdMapped = rdStat || rdIrta || rdCmd;
  wire [31:0] statWord = {3'h0, stat_q, 24'h000000};
  wire [31:0] rdWord = rdStat ? statWord : (rdIrta ? irtAddr_q : 32'h00000000);

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RGC_RESP_OKAY;
    end else begin
      awready_q <= !awready_q && awvalid && wvalid && !bvalid_q && idle;
      if (wrTake) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? RGC_RESP_OKAY : RGC_RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RGC_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      arready_q <= !arready_q && arvalid && !rvalid_q;
      if (rdTake) begin
        rvalid_q <= 1'b1;
        rresp_q <= rdMapped ? RGC_RESP_OKAY : RGC_RESP_SLVERR;
        rdata_q <= rdWord;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Table address register, per byte lane
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : gLane
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          irtAddr_q[b*8 +: 8] <= RGC_IRTA_RST[b*8 +: 8];
        end else if (irtaWr && wstrb[b]) begin
          irtAddr_q[b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      RGC_IDLE: begin
        if (pendLoad_q) begin
          state_d = RGC_LOAD;
        end else if (pendFlush_q) begin
          state_d = RGC_FLUSH;
        end else if (pendIr_q) begin
          state_d = RGC_DRAIN;
        end
      end
      RGC_LOAD: begin
        state_d = RGC_IDLE;
      end
      RGC_FLUSH: begin
        if (flushDoneS) begin
          state_d = RGC_IDLE;
        end
      end
      RGC_DRAIN: begin
        if (irqIdleS) begin
          state_d = RGC_IDLE;
        end
      end
      default: begin
        state_d = RGC_IDLE;
      end
    endcase
  end

  wire loadDone = (state_q == RGC_LOAD);
  wire flushDone = (state_q == RGC_FLUSH) && flushDoneS;
  wire drainDone = (state_q == RGC_DRAIN) && irqIdleS;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= RGC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pendLoad_q <= 1'b0;
      pendFlush_q <= 1'b0;
      pendIr_q <= 1'b0;
      irTarget_q <= 1'b0;
    end else begin
      pendLoad_q <= wrTp || (pendLoad_q && !loadDone);
      pendFlush_q <= wrWbf || (pendFlush_q && !flushDone);
      pendIr_q <= wrIr || (pendIr_q && !drainDone);
      if (wrIr) begin
        irTarget_q <= wdata[RGC_IR_BIT];
      end
    end
  end

  // ----------------------------------------
  // Feature controls and status
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      faultLogMem <= 1'b0;
      queuedInvalOn <= 1'b0;
      irqRemapOn <= 1'b0;
      irtPtr <= RGC_IRTP_RST;
      flushReq <= 1'b0;
      stat_q <= RGC_STAT_RST;
    end else begin
      if (wrFl) begin
        faultLogMem <= wdata[RGC_FL_BIT];
        stat_q.faultLog <= wdata[RGC_FL_BIT];
      end
      if (wrQi) begin
        queuedInvalOn <= wdata[RGC_QI_BIT];
        stat_q.queuedInval <= wdata[RGC_QI_BIT];
      end
      if (wrWbf) begin
        stat_q.flush <= 1'b1;
      end else if (flushDone) begin
        stat_q.flush <= 1'b0;
      end
      flushReq <= (state_d == RGC_FLUSH);
      if (drainDone) begin
        irqRemapOn <= irTarget_q;
        stat_q.irqRemap <= irTarget_q;
      end
      if (wrTp) begin
        stat_q.tablePtr <= 1'b0;
      end else if (loadDone) begin
        irtPtr <= irtAddr_q;
        stat_q.tablePtr <= 1'b1;
      end
    end
  end

  assign awready = awready_q;
  assign wready = awready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seqFlushStart;
    wrWbf;
  endsequence
  sequence seqFlushHold;
    stat_q.flush && !flushDoneS;
  endsequence

  AST_FLUSH_SET: assert property (seqFlushStart |=> stat_q.flush)
    else $error("Flush status not set by flush request");
  AST_FLUSH_HOLD: assert property (seqFlushStart ##1 seqFlushHold |=> stat_q.flush)
    else $error("Flush status cleared before flush finished");
  AST_FLUSH_CLR: assert property ($fell(stat_q.flush) |-> $past(flushDoneS))
    else $error("Flush status fell without completion");
  AST_FLUSH_REQ: assert property (seqFlushStart |=> ##[1:2] flushReq)
    else $error("Flush request not raised");
  AST_IR_DRAIN: assert property ($changed(irqRemapOn) |-> $past(irqIdleS))
    else $error("Remap switched without drained queue");
  AST_IR_STAT: assert property (stat_q.irqRemap == irqRemapOn)
    else $error("Remap status differs from remap state");
  AST_TP_LOAD: assert property ($rose(stat_q.tablePtr) |-> irtPtr == $past(irtAddr_q))
    else $error("Pointer status set without pointer load");
  AST_TP_CLR: assert property (wrTp |=>
    !stat_q.tablePtr ##1 (pendLoad_q || stat_q.tablePtr))
    else $error("Pointer status not cleared on load request");
  AST_FL_WR: assert property (wrFl |=> faultLogMem == $past(wdata[RGC_FL_BIT]))
    else $error("Fault log select not taken");
  AST_QI_WR: assert property (wrQi |=>
    queuedInvalOn == $past(wdata[RGC_QI_BIT]) && stat_q.queuedInval == $past(wdata[RGC_QI_BIT]))
    else $error("Queued invalidation status mismatch");
  AST_RESERVED: assert property (cmdWr && !supFl && !faultLogMem |=> !faultLogMem)
    else $error("Unsupported fault log field took a write");
  AST_B_RESP: assert property (wrTake |=> bvalid ##0
    bresp == $past(wrMapped ? RGC_RESP_OKAY : RGC_RESP_SLVERR))
    else $error("Write response missing or wrong");
endmodule
`default_nettype wire

/* File: tb/rgc_global_command_tb.sv */
// Purpose: Self-checking bench for the remap global command block
// Assumes: uut has every feature on; spare instance keeps the default mask
// Notes: Bus tasks act as an AXI4-Lite master, one transfer at a time
`timescale 1ns/1ns
`default_nettype none
module rgc_global_command_tb;
  import rgc_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [RGC_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic flushDonePin = 1'h0, irqIdlePin = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, flushReq, faultLogMem;
  logic queuedInvalOn, irqRemapOn, zFlush, zLog, zQueued, zRemap;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, irtPtr, zPtr, rd;
  logic [5:0] flags;
  int n_fail = 0, check_count = 0;

  always #10 mclk = ~mclk;
  // Waitable levels: 5 write ready, 4 bvalid, 3 arready, 2 rvalid, 1 flush, 0 remap
  assign flags = {awready & wready, bvalid, arready, rvalid, flushReq, irqRemapOn};

  rgc_global_command #(.SUPPORT(5'h1F)) uut (
    .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .flushDonePin, .irqIdlePin, .flushReq, .faultLogMem,
    .queuedInvalOn, .irqRemapOn, .irtPtr
  );
  rgc_global_command spare (
    .mclk, .rst, .awaddr, .awvalid, .awready(), .wdata, .wstrb, .wvalid,
    .wready(), .bresp(), .bvalid(), .bready, .araddr, .arvalid, .arready(),
    .rdata(), .rresp(), .rvalid(), .rready, .flushDonePin, .irqIdlePin,
    .flushReq(zFlush), .faultLogMem(zLog), .queuedInvalOn(zQueued),
    .irqRemapOn(zRemap), .irtPtr(zPtr)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_on(input int idx, input logic val);
    int n;
    for (n = 0; n <= 200; n++) begin
      @(posedge mclk);
      if (flags[idx] === val) break;
    end
    if (n > 200) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    wait_on(5, 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    wait_on(4, 1'h1);
    r = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    wait_on(3, 1'h1);
    arvalid <= 1'h0;
    wait_on(2, 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic cmd(input logic [4:0] f);
    wr(RGC_CMD_OFF, {3'h0, f, 24'h000000}, rsp);
  endtask
  task automatic stat(input logic [4:0] e);
    rdw(RGC_STAT_OFF, rd, rsp);
    check(rd, {3'h0, e, 24'h000000});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({flushReq, faultLogMem, queuedInvalOn, irqRemapOn}, 32'h0);
    check(irtPtr, RGC_IRTP_RST);
    stat(5'h00);
    wr(RGC_STAT_OFF, 32'h1F000000, rsp);
    stat(5'h00);
    wr(8'h40, 32'hFFFFFFFF, rsp);
    check(rsp, RGC_RESP_SLVERR);
    rdw(8'h40, rd, rsp);
    check(rd, 32'h0);
    check(rsp, RGC_RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_modes();
    cmd(5'h10);
    check(faultLogMem, 1'h1);
    stat(5'h10);
    cmd(5'h04);
    check({faultLogMem, queuedInvalOn}, 2'h1);
    stat(5'h04);
    cmd(5'h00);
    check({faultLogMem, queuedInvalOn}, 2'h0);
    stat(5'h00);
    $display("mode test done");
  endtask
  task automatic t_flush();
    cmd(5'h08);
    stat(5'h08);
    wait_on(1, 1'h1);
    repeat (6) @(posedge mclk);
    check(flushReq, 1'h1);
    stat(5'h08);
    flushDonePin <= 1'h1;
    wait_on(1, 1'h0);
    stat(5'h00);
    flushDonePin <= 1'h0;
    repeat (4) @(posedge mclk);
    cmd(5'h00);
    repeat (4) @(posedge mclk);
    check(flushReq, 1'h0);
    $display("flush test done");
  endtask
  task automatic t_remap();
    cmd(5'h02);
    repeat (6) @(posedge mclk);
    check(irqRemapOn, 1'h0);
    stat(5'h01);
    irqIdlePin <= 1'h1;
    wait_on(0, 1'h1);
    stat(5'h03);
    cmd(5'h03);
    repeat (4) @(posedge mclk);
    check(irqRemapOn, 1'h1);
    check(irtPtr, 32'h5A5A2000);
    stat(5'h03);
    cmd(5'h00);
    wait_on(0, 1'h0);
    stat(5'h01);
    irqIdlePin <= 1'h0;
    $display("remap test done");
  endtask
  task automatic t_table();
    wr(RGC_IRTA_OFF, 32'hA5A51000, rsp);
    cmd(5'h01);
    repeat (4) @(posedge mclk);
    check(irtPtr, 32'hA5A51000);
    stat(5'h01);
    wr(RGC_IRTA_OFF, 32'h5A5A2000, rsp);
    rdw(RGC_IRTA_OFF, rd, rsp);
    check(rd, 32'h5A5A2000);
    cmd(5'h00);
    repeat (4) @(posedge mclk);
    check(irtPtr, 32'hA5A51000);
    stat(5'h01);
    check({zFlush, zLog, zQueued, zRemap}, 32'h0);
    check(zPtr, 32'h0);
    $display("table test done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset();
    t_modes();
    t_flush();
    t_table();
    t_remap();
    conclude();
  end
endmodule
`default_nettype wire
